// file: logic/seu_pkg.sv
// constants and helpers for the standard event status unit
// How it works
// - the host writes any value 0 to 255 into the enable mask
// - summary bit is high when any latched event has its mask bit set
// - a mask query replies with the mask and leaves it unchanged
// - mask writes and queries work in local and in remote state alike
// - an event query replies with the latch, then reloads it with only that cycle's new events
// - the reply is one decimal number, weighted sum of bits 0 to 7
// - bit 7 (128) is set after the power-on transition
// - bit 6 (64) is set on an operator request
// - bit 5 (32) is set on a command parser error
// - bit 4 (16) is set on an execution error
// - bit 3 (8) is set on a device specific error
// - bit 2 (4) is set on a query error
// - bit 1, the bus control request flag, always reads zero
// - bit 0, the operation done flag, is unused and reads zero
// - a syntax error sets the parser error bit and records its code
// - reading with no reply, or commanding over an unread reply, is a query error
package seu_pkg;

    // ************************************************************
    // register reset values
    // ************************************************************
    localparam logic [7:0] SEU_MASK_RST = 8'h00;
    localparam logic [7:0] SEU_LATCH_RST = 8'h00;
    localparam logic [7:0] SEU_CODE_RST = 8'h00;

    // ************************************************************
    // event bit positions
    // ************************************************************
    localparam int SEU_BIT_POWER_ON = 7;
    localparam int SEU_BIT_OPERATOR = 6;
    localparam int SEU_BIT_PARSER = 5;
    localparam int SEU_BIT_EXEC = 4;
    localparam int SEU_BIT_FAULT = 3;
    localparam int SEU_BIT_QUERY = 2;
    localparam logic [7:0] SEU_LIVE_BITS = 8'hFC;

    // ************************************************************
    // command codes and parser error code for a bad command
    // ************************************************************
    localparam logic [1:0] SEU_OP_MASK_WR = 2'h0;
    localparam logic [1:0] SEU_OP_MASK_RD = 2'h1;
    localparam logic [1:0] SEU_OP_EVENT_RD = 2'h2;
    localparam logic [7:0] SEU_CODE_BAD_OP = 8'h01;

    // ************************************************************
    // binary to three decimal digits
    // ************************************************************
    function automatic logic [11:0] seu_to_decimal(input logic [7:0] v);
        logic [7:0] h;
        logic [7:0] t;
        logic [7:0] o;
        h = v / 8'h64;
        t = (v % 8'h64) / 8'h0A;
        o = v % 8'h0A;
        return {h[3:0], t[3:0], o[3:0]};
    endfunction : seu_to_decimal

endpackage : seu_pkg

// file: logic/seu_event_latch.sv
// sticky event latch with read-clear and masked summary
`timescale 1ns/10ps
module seu_event_latch import seu_pkg::*; (
    // clock, reset, enable
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ce,
    // event sets, query clear, next mask
    input wire logic [7:0] set_vec,
    input wire logic clear,
    input wire logic [7:0] mask_next,
    // latched state
    output logic [7:0] latch_q,
    output logic summary_q
);

    // ************************************************************
    // latch and summary
    // ************************************************************
    logic [7:0] latch_reg;
    logic [7:0] latch_next;
    logic summary_reg;
    logic summary_next;

    always_comb begin
        if (clear) begin
            latch_next = set_vec;
        end else begin
            latch_next = latch_reg | set_vec;
        end
        latch_next = latch_next & SEU_LIVE_BITS;
        summary_next = |(latch_next & mask_next);
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            latch_reg <= SEU_LATCH_RST;
            summary_reg <= 1'b0;
        end else if (ce) begin
            latch_reg <= latch_next;
            summary_reg <= summary_next;
        end
    end

    assign latch_q = latch_reg;
    assign summary_q = summary_reg;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    latch_hold_a: assert property (ce && !clear |=> (latch_q & $past(latch_q)) == $past(latch_q))
        else $error("event bit dropped without a query");
    query_clear_a: assert property (ce && clear |=> latch_q == ($past(set_vec) & SEU_LIVE_BITS))
        else $error("event query did not clear the latch");
    ctl_req_zero_a: assert property (latch_q[1] == 1'b0)
        else $error("bus control request flag set");
    done_zero_a: assert property (latch_q[0] == 1'b0)
        else $error("operation done flag set");
    summary_bit_a: assert property (ce |=> summary_q == |(latch_q & $past(mask_next)))
        else $error("summary bit disagrees with masked latch");

endmodule : seu_event_latch

// file: logic/seu_top.sv
// standard event status unit: enable mask, event latch, command replies
`timescale 1ns/10ps
module seu_top import seu_pkg::*; (
    // clock, reset, enable
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ce,
    // status commands from the parser
    input wire logic cmd_valid,
    input wire logic [1:0] cmd_op,
    input wire logic [7:0] cmd_value,
    // host read of the reply
    input wire logic host_read,
    // reply to the host
    output logic reply_valid,
    output logic [7:0] reply_value,
    output logic [11:0] reply_decimal,
    // event sources
    input wire logic operator_request_event,
    input wire logic parser_error_event,
    input wire logic [7:0] parser_error_code,
    input wire logic execution_error_event,
    input wire logic device_fault_event,
    input wire logic query_error_event,
    // status outputs
    output logic [7:0] event_enable_mask,
    output logic [7:0] event_status_latch,
    output logic event_summary_bit,
    output logic [7:0] parser_code_last
);

    // ************************************************************
    // state
    // ************************************************************
    logic [7:0] mask_reg;
    logic [7:0] mask_next;
    logic reply_valid_reg;
    logic reply_valid_next;
    logic [7:0] reply_value_reg;
    logic [7:0] reply_value_next;
    logic [11:0] reply_dec_reg;
    logic [11:0] reply_dec_next;
    logic [7:0] code_reg;
    logic [7:0] code_next;
    logic power_on_reg;
    logic power_on_next;
    logic [7:0] set_vec;
    logic latch_clear;
    logic reply_stale;
    logic [7:0] latch_q;
    logic summary_q;

    // ************************************************************
    // command handling and event collection
    // ************************************************************
    always_comb begin
        mask_next = mask_reg;
        reply_valid_next = reply_valid_reg;
        reply_value_next = reply_value_reg;
        code_next = code_reg;
        power_on_next = 1'b0;
        set_vec = 8'h00;
        latch_clear = 1'b0;
        reply_stale = reply_valid_reg && !host_read;
        set_vec[SEU_BIT_POWER_ON] = power_on_reg;
        set_vec[SEU_BIT_OPERATOR] = operator_request_event;
        set_vec[SEU_BIT_PARSER] = parser_error_event;
        set_vec[SEU_BIT_EXEC] = execution_error_event;
        set_vec[SEU_BIT_FAULT] = device_fault_event;
        set_vec[SEU_BIT_QUERY] = query_error_event;
        if (parser_error_event) begin
            code_next = parser_error_code;
        end
        if (host_read) begin
            if (reply_valid_reg) begin
                reply_valid_next = 1'b0;
            end else begin
                set_vec[SEU_BIT_QUERY] = 1'b1;
            end
        end
        // commands run regardless of local or remote state
        if (cmd_valid) begin
            if (reply_stale) begin
                set_vec[SEU_BIT_QUERY] = 1'b1;
                reply_valid_next = 1'b0;
            end
            case (cmd_op)
                SEU_OP_MASK_WR: begin
                    mask_next = cmd_value;
                end
                SEU_OP_MASK_RD: begin
                    reply_valid_next = 1'b1;
                    reply_value_next = mask_reg;
                end
                SEU_OP_EVENT_RD: begin
                    reply_valid_next = 1'b1;
                    reply_value_next = latch_q;
                    latch_clear = 1'b1;
                end
                default: begin
                    set_vec[SEU_BIT_PARSER] = 1'b1;
                    code_next = SEU_CODE_BAD_OP;
                end
            endcase
        end
        reply_dec_next = seu_to_decimal(reply_value_next);
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            mask_reg <= SEU_MASK_RST;
            reply_valid_reg <= 1'b0;
            reply_value_reg <= 8'h00;
            reply_dec_reg <= 12'h000;
            code_reg <= SEU_CODE_RST;
            power_on_reg <= 1'b1;
        end else if (ce) begin
            mask_reg <= mask_next;
            reply_valid_reg <= reply_valid_next;
            reply_value_reg <= reply_value_next;
            reply_dec_reg <= reply_dec_next;
            code_reg <= code_next;
            power_on_reg <= power_on_next;
        end
    end

    // ************************************************************
    // event latch
    // ************************************************************
    seu_event_latch u_latch (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .ce(ce),
        .set_vec(set_vec),
        .clear(latch_clear),
        .mask_next(mask_next),
        .latch_q(latch_q),
        .summary_q(summary_q)
    );

    // ************************************************************
    // outputs
    // ************************************************************
    assign reply_valid = reply_valid_reg;
    assign reply_value = reply_value_reg;
    assign reply_decimal = reply_dec_reg;
    assign event_enable_mask = mask_reg;
    assign event_status_latch = latch_q;
    assign event_summary_bit = summary_q;
    assign parser_code_last = code_reg;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence s_cmd(logic [1:0] op);
        ce && cmd_valid && cmd_op == op;
    endsequence

    sequence s_quiet;
        !operator_request_event && !parser_error_event && !execution_error_event
            && !device_fault_event && !query_error_event && !power_on_reg;
    endsequence

    sequence s_event_query_clean;
        s_cmd(SEU_OP_EVENT_RD) and s_quiet and (!reply_valid && !host_read);
    endsequence

    mask_store_a: assert property (s_cmd(SEU_OP_MASK_WR) |=> event_enable_mask == $past(cmd_value))
        else $error("mask write not stored");
    mask_query_a: assert property (s_cmd(SEU_OP_MASK_RD) |=>
        reply_valid && reply_value == $past(event_enable_mask) && $stable(event_enable_mask))
        else $error("mask query reply wrong or mask changed");
    event_reply_a: assert property (s_cmd(SEU_OP_EVENT_RD) |=>
        reply_valid && reply_value == $past(event_status_latch))
        else $error("event query reply differs from latch");
    event_clear_a: assert property (s_event_query_clean |=> event_status_latch == 8'h00)
        else $error("event query left bits set");
    decimal_reply_a: assert property (reply_valid |->
        int'(reply_decimal[11:8]) * 100 + int'(reply_decimal[7:4]) * 10 + int'(reply_decimal[3:0])
        == int'(reply_value))
        else $error("decimal reply does not match value");
    power_on_a: assert property ($fell(sys_rst) ##0 ce [*2] |-> event_status_latch[SEU_BIT_POWER_ON])
        else $error("power-on bit not set after reset");
    operator_req_a: assert property (ce && operator_request_event |=> event_status_latch[SEU_BIT_OPERATOR])
        else $error("operator request not latched");
    parser_err_a: assert property (ce && parser_error_event && !(cmd_valid && cmd_op == 2'h3) |=>
        event_status_latch[SEU_BIT_PARSER] && parser_code_last == $past(parser_error_code))
        else $error("parser error not latched");
    exec_err_a: assert property (ce && execution_error_event |=> event_status_latch[SEU_BIT_EXEC])
        else $error("execution error not latched");
    dev_fault_a: assert property (ce && device_fault_event |=> event_status_latch[SEU_BIT_FAULT])
        else $error("device fault not latched");
    query_err_a: assert property (ce && query_error_event |=> event_status_latch[SEU_BIT_QUERY])
        else $error("query error not latched");
    bad_op_a: assert property (ce && cmd_valid && cmd_op == 2'h3 |=>
        event_status_latch[SEU_BIT_PARSER] && parser_code_last == SEU_CODE_BAD_OP)
        else $error("bad command not reported");
    empty_read_a: assert property (ce && host_read && !reply_valid |=> event_status_latch[SEU_BIT_QUERY])
        else $error("read with no reply not flagged");
    stale_reply_a: assert property (ce && cmd_valid && reply_valid && !host_read |=>
        event_status_latch[SEU_BIT_QUERY])
        else $error("command over unread reply not flagged");

endmodule : seu_top

// file: verification/seu_host_model.sv
// host controller model: status commands, queries and reply reads
`timescale 1ns/10ps
module seu_host_model import seu_pkg::*; (
    // clock
    input wire logic mclk,
    // command and read strobes
    output logic cmd_valid,
    output logic [1:0] cmd_op,
    output logic [7:0] cmd_value,
    output logic host_read,
    // reply from the device
    input wire logic reply_valid,
    input wire logic [7:0] reply_value,
    input wire logic [11:0] reply_decimal
);
    initial begin
        cmd_valid = 1'b0;
        cmd_op = 2'h3;
        cmd_value = 8'h00;
        host_read = 1'b0;
    end

    // one command for one edge, then the idle lines are scrambled
    task automatic send(input logic [1:0] op, input logic [7:0] value);
        @(negedge mclk);
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_value = value;
        @(negedge mclk);
        cmd_valid = 1'b0;
        cmd_op = ~op;
        cmd_value = ~value;
    endtask : send

    // read strobe whether or not a reply is held
    task automatic strobe_read;
        host_read = 1'b1;
        @(negedge mclk);
        host_read = 1'b0;
    endtask : strobe_read

    // wait a few cycles for the reply, take it, then strobe the read
    task automatic fetch(output logic [7:0] value, output logic [11:0] dec, output logic ok);
        int n;
        n = 0;
        while (reply_valid !== 1'b1 && n < 4) begin
            @(negedge mclk);
            n++;
        end
        ok = (reply_valid === 1'b1);
        value = reply_value;
        dec = reply_decimal;
        strobe_read();
    endtask : fetch
endmodule : seu_host_model

// file: verification/testbench.sv
// self-checking testbench of the standard event status unit
`timescale 1ns/10ps
module testbench import seu_pkg::*;;
    logic mclk, sys_rst, ce, cmd_valid, host_read, reply_valid, event_summary_bit;
    logic [1:0] cmd_op;
    logic [7:0] cmd_value, reply_value, event_enable_mask, event_status_latch, parser_code_last, parser_error_code;
    logic [11:0] reply_decimal;
    logic operator_request_event, parser_error_event, execution_error_event, device_fault_event, query_error_event;
    int fail_count, n_compared;
    logic [7:0] masks [3] = '{8'hFF, 8'h00, 8'h48};

    seu_top seu_top_inst (.mclk, .sys_rst, .ce, .cmd_valid, .cmd_op, .cmd_value, .host_read, .reply_valid,
        .reply_value, .reply_decimal, .operator_request_event, .parser_error_event, .parser_error_code,
        .execution_error_event, .device_fault_event, .query_error_event, .event_enable_mask,
        .event_status_latch, .event_summary_bit, .parser_code_last);
    seu_host_model seu_host_model_inst (.mclk, .cmd_valid, .cmd_op, .cmd_value, .host_read, .reply_valid,
        .reply_value, .reply_decimal);

    always #5 mclk = ~mclk;

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [11:0] to_bcd(input logic [7:0] v);
        return {4'(v / 100), 4'((v / 10) % 10), 4'(v % 10)};
    endfunction : to_bcd

    task automatic query(input logic [1:0] op, input logic [7:0] exp);
        logic [7:0] v;
        logic [11:0] d;
        logic ok;
        seu_host_model_inst.send(op, 8'h00);
        seu_host_model_inst.fetch(v, d, ok);
        if (!ok) begin
            fail_count++;
            $display("Error at %0t: no reply", $time);
        end
        check(v, exp);
        check(d, to_bcd(exp));
        check(reply_valid, 1'b0);
    endtask : query

    task automatic pulse(input logic [4:0] sel);
        @(negedge mclk);
        {operator_request_event, parser_error_event, execution_error_event, device_fault_event,
            query_error_event} = sel;
        @(negedge mclk);
        {operator_request_event, parser_error_event, execution_error_event, device_fault_event,
            query_error_event} = 5'h00;
    endtask : pulse

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        fail_count = 0;
        n_compared = 0;
        mclk = 1'b0;
        sys_rst = 1'b1;
        ce = 1'b1;
        parser_error_code = 8'h2A;
        {operator_request_event, parser_error_event, execution_error_event, device_fault_event,
            query_error_event} = 5'h00;
        repeat (2) @(negedge mclk);
        check(event_enable_mask, SEU_MASK_RST);
        check(event_status_latch, SEU_LATCH_RST);
        sys_rst = 1'b0;
        @(negedge mclk);
        check(event_status_latch, 8'h80);
        check(event_summary_bit, 1'b0);
        query(SEU_OP_EVENT_RD, 8'h80);
        query(SEU_OP_EVENT_RD, 8'h00);
        $display("test power-on and clear done");
        foreach (masks[i]) begin
            seu_host_model_inst.send(SEU_OP_MASK_WR, masks[i]);
            check(event_enable_mask, masks[i]);
            query(SEU_OP_MASK_RD, masks[i]);
            check(event_enable_mask, masks[i]);
        end
        $display("test mask write and query done");
        for (int i = 0; i < 5; i++) begin
            pulse(5'h01 << i);
            check(event_status_latch, {1'b0, 5'h01 << i, 2'b00});
            check(event_summary_bit, (i == 1 || i == 4));
            query(SEU_OP_EVENT_RD, {1'b0, 5'h01 << i, 2'b00});
        end
        check(parser_code_last, 8'h2A);
        pulse(5'h1F);
        check(event_summary_bit, 1'b1);
        seu_host_model_inst.send(SEU_OP_MASK_WR, 8'h00);
        check(event_summary_bit, 1'b0);
        query(SEU_OP_EVENT_RD, 8'h7C);
        $display("test event sources done");
        seu_host_model_inst.send(2'h3, 8'h00);
        check(event_status_latch, 8'h20);
        check(parser_code_last, SEU_CODE_BAD_OP);
        query(SEU_OP_EVENT_RD, 8'h20);
        @(negedge mclk);
        seu_host_model_inst.strobe_read();
        check(event_status_latch, 8'h04);
        query(SEU_OP_EVENT_RD, 8'h04);
        seu_host_model_inst.send(SEU_OP_MASK_RD, 8'h00);
        seu_host_model_inst.send(SEU_OP_MASK_WR, 8'h11);
        check(event_status_latch, 8'h04);
        check(event_enable_mask, 8'h11);
        query(SEU_OP_EVENT_RD, 8'h04);
        $display("test refusals and query errors done");
        test_done();
    end
endmodule : testbench
